//--- verilog/speed_status_outputs.sv
// Speed status flags and their routing onto digital output terminals.
`include "speed_status_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module speed_status_outputs
  import speed_status_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Speed samples, signed rpm, valid on sample_update.
  input wire logic sample_update,
  input wire logic signed [`SPD_W-1:0] motor_speed,
  input wire logic signed [`SPD_W-1:0] speed_command,
  // Threshold settings, loaded when thr_write is high.
  input wire logic thr_write,
  input wire thresholds_t thr_req,
  // Function selection of each output terminal.
  input wire logic [`DO_NUM*`FUNC_W-1:0] do_function,
  // Flags and terminals.
  output speed_flags_t flags,
  output logic [`DO_NUM-1:0] do_out,
  output thresholds_t thr_now
);
  thresholds_t thr_r, thr_nxt, thr_clamped;
  speed_flags_t flags_r, flags_nxt;
  logic [`DO_NUM-1:0] do_r, do_nxt;
  logic [`SPD_W:0] abs_speed, abs_diff;
  logic signed [`SPD_W:0] diff;

  // Out-of-range writes are clamped, so the comparators never see an illegal limit.
  threshold_clamp #(.MIN_VAL(`ROT_THR_MIN), .MAX_VAL(`ROT_THR_MAX)) u_rot (
    .req(thr_req.rotation),
    .value(thr_clamped.rotation)
  );
  threshold_clamp #(.MIN_VAL(`ZERO_THR_MIN), .MAX_VAL(`ZERO_THR_MAX)) u_zero (
    .req(thr_req.zero),
    .value(thr_clamped.zero)
  );
  threshold_clamp #(.MIN_VAL(`MATCH_THR_MIN), .MAX_VAL(`MATCH_THR_MAX)) u_mat (
    .req(thr_req.match),
    .value(thr_clamped.match)
  );
  threshold_clamp #(.MIN_VAL(`APPR_THR_MIN), .MAX_VAL(`APPR_THR_MAX)) u_app (
    .req(thr_req.approach),
    .value(thr_clamped.approach)
  );

  function automatic logic [`SPD_W:0] mag(input logic signed [`SPD_W:0] v);
    mag = v[`SPD_W] ? 17'(-v) : 17'(v);
  endfunction

  always_comb begin
    thr_nxt = thr_r;
    if (thr_write) begin
      thr_nxt = thr_clamped;
    end
  end

  // The wider difference keeps full-scale opposite speeds from wrapping.
  always_comb begin
    diff = 17'(signed'(motor_speed)) - 17'(signed'(speed_command));
    abs_speed = mag(17'(signed'(motor_speed)));
    abs_diff = mag(diff);
    flags_nxt = flags_r;
    if (sample_update) begin
      flags_nxt.rotation = abs_speed >= 17'(thr_r.rotation);
      flags_nxt.zero = abs_speed < 17'(thr_r.zero);
      flags_nxt.match = abs_diff <= 17'(thr_r.match);
      flags_nxt.near = abs_speed > 17'(thr_r.approach);
    end
  end

  // Unknown codes keep a terminal low, so a mis-set terminal shows no flag.
  function automatic logic route(input logic [`FUNC_W-1:0] code,
      input speed_flags_t f);
    unique case (code)
      `FUNC_ROTATION: route = f.rotation;
      `FUNC_ZERO_SPEED: route = f.zero;
      `FUNC_SPEED_MATCH: route = f.match;
      `FUNC_SPEED_NEAR: route = f.near;
      default: route = 1'b0;
    endcase
  endfunction

  // Terminals follow the registered flags, one cycle behind them.
  always_comb begin
    for (int i = 0; i < `DO_NUM; i++) begin
      do_nxt[i] = route(do_function[i*`FUNC_W +: `FUNC_W], flags_r);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      thr_r <= {`ROT_THR_RST, `ZERO_THR_RST, `MATCH_THR_RST, `APPR_THR_RST};
      flags_r <= '0;
      do_r <= '0;
    end else begin
      thr_r <= thr_nxt;
      flags_r <= flags_nxt;
      do_r <= do_nxt;
    end
  end

  assign flags = flags_r;
  assign do_out = do_r;
  assign thr_now = thr_r;

  // Reset values are checked without the reset gate, so a held reset counts.
  a_reset_flags: assert property (@(posedge clk_sys)
    !rst_b |=> flags == '0 && do_out == '0)
    else $error("flags not cleared by reset");
  a_reset_thr: assert property (@(posedge clk_sys)
    !rst_b |=> thr_now == {`ROT_THR_RST, `ZERO_THR_RST, `MATCH_THR_RST,
      `APPR_THR_RST}) else $error("limits not reset");
  a_rot_flag: assert property (@(posedge clk_sys)
    disable iff (!rst_b) sample_update |=> flags.rotation ==
      ($past(abs_speed) >= 17'($past(thr_r.rotation))))
    else $error("rotation flag wrong");
  a_rot_clear: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    sample_update && abs_speed < 17'(thr_r.rotation) |=> !flags.rotation)
    else $error("rotation flag not cleared");
  a_rot_range: assert property (@(posedge clk_sys)
    disable iff (!rst_b) thr_now.rotation <= `ROT_THR_MAX)
    else $error("rotation limit range");
  a_rot_take: assert property (@(posedge clk_sys)
    disable iff (!rst_b) thr_write |=> thr_now.rotation ==
      ($past(thr_req.rotation) > `ROT_THR_MAX ? `ROT_THR_MAX :
        $past(thr_req.rotation))) else $error("rotation limit not taken");
  a_zero_flag: assert property (@(posedge clk_sys)
    disable iff (!rst_b) sample_update |=> flags.zero ==
      ($past(abs_speed) < 17'($past(thr_r.zero))))
    else $error("zero flag wrong");
  a_zero_clear: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    sample_update && abs_speed >= 17'(thr_r.zero) |=> !flags.zero)
    else $error("zero flag not cleared");
  a_zero_range: assert property (@(posedge clk_sys)
    disable iff (!rst_b) thr_now.zero <= `ZERO_THR_MAX)
    else $error("zero limit range");
  a_zero_take: assert property (@(posedge clk_sys)
    disable iff (!rst_b) thr_write |=> thr_now.zero ==
      ($past(thr_req.zero) > `ZERO_THR_MAX ? `ZERO_THR_MAX :
        $past(thr_req.zero))) else $error("zero limit not taken");
  a_match_flag: assert property (@(posedge clk_sys)
    disable iff (!rst_b) sample_update |=> flags.match ==
      ($past(abs_diff) <= 17'($past(thr_r.match))))
    else $error("match flag wrong");
  a_match_clear: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    sample_update && abs_diff > 17'(thr_r.match) |=> !flags.match)
    else $error("match flag not cleared");
  a_match_range: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    thr_write |=> thr_now.match <= `MATCH_THR_MAX)
    else $error("match limit range");
  a_match_take: assert property (@(posedge clk_sys)
    disable iff (!rst_b) thr_write |=> thr_now.match ==
      ($past(thr_req.match) > `MATCH_THR_MAX ? `MATCH_THR_MAX :
        $past(thr_req.match))) else $error("match limit not taken");
  a_near_flag: assert property (@(posedge clk_sys)
    disable iff (!rst_b) sample_update |=> flags.near ==
      ($past(abs_speed) > 17'($past(thr_r.approach))))
    else $error("near flag wrong");
  a_near_clear: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    sample_update && abs_speed <= 17'(thr_r.approach) |=> !flags.near)
    else $error("near flag not cleared");
  a_appr_range: assert property (@(posedge clk_sys)
    disable iff (!rst_b)
    thr_now.approach >= `APPR_THR_MIN && thr_now.approach <= `APPR_THR_MAX)
    else $error("approach limit range");
  a_appr_take: assert property (@(posedge clk_sys)
    disable iff (!rst_b) thr_write |=> thr_now.approach ==
      ($past(thr_req.approach) < `APPR_THR_MIN ? `APPR_THR_MIN :
        $past(thr_req.approach) > `APPR_THR_MAX ? `APPR_THR_MAX :
        $past(thr_req.approach)))
    else $error("approach limit not taken");
  a_thr_hold: assert property (@(posedge clk_sys)
    disable iff (!rst_b) !thr_write |=> $stable(thr_now))
    else $error("limits moved without a write");
  a_flags_hold: assert property (@(posedge clk_sys)
    disable iff (!rst_b) !sample_update |=> $stable(flags))
    else $error("flags moved");

  // Each terminal is checked on its own, since any of them may take any code.
  for (genvar g = 0; g < `DO_NUM; g++) begin : g_term_chk
    a_term_rot: assert property (@(posedge clk_sys)
      disable iff (!rst_b)
      do_function[g*`FUNC_W +: `FUNC_W] == `FUNC_ROTATION |=>
      do_out[g] == $past(flags.rotation))
      else $error("rotation routing wrong");
    a_term_zero: assert property (@(posedge clk_sys)
      disable iff (!rst_b)
      do_function[g*`FUNC_W +: `FUNC_W] == `FUNC_ZERO_SPEED |=>
      do_out[g] == $past(flags.zero))
      else $error("zero routing wrong");
    a_term_match: assert property (@(posedge clk_sys)
      disable iff (!rst_b)
      do_function[g*`FUNC_W +: `FUNC_W] == `FUNC_SPEED_MATCH |=>
      do_out[g] == $past(flags.match))
      else $error("match routing wrong");
    a_term_near: assert property (@(posedge clk_sys)
      disable iff (!rst_b)
      do_function[g*`FUNC_W +: `FUNC_W] == `FUNC_SPEED_NEAR |=>
      do_out[g] == $past(flags.near))
      else $error("near routing wrong");
    a_term_idle: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !(do_function[g*`FUNC_W +: `FUNC_W] inside {`FUNC_ROTATION,
        `FUNC_ZERO_SPEED, `FUNC_SPEED_MATCH, `FUNC_SPEED_NEAR}) |=>
      !do_out[g]) else $error("unassigned terminal driven");
  end

  c_rot_rise: cover property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(flags.rotation));
  c_near_rise: cover property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(flags.near));
  c_zero_fall: cover property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(flags.zero));
  c_match_do: cover property (@(posedge clk_sys) disable iff (!rst_b)
    do_out[1] && do_function[2*`FUNC_W-1:`FUNC_W] == `FUNC_SPEED_MATCH);
  c_thr_clamp: cover property (@(posedge clk_sys) disable iff (!rst_b)
    thr_write && thr_req.approach < `APPR_THR_MIN);
endmodule
`default_nettype wire

//--- verilog/speed_status_cfg.svh
// Constants for the speed status comparator block.
`ifndef SPEED_STATUS_CFG_SVH
`define SPEED_STATUS_CFG_SVH
// Overview of operation
// - Rotation flag set when absolute filtered speed reaches rotation threshold.
// - Rotation flag cleared when absolute filtered speed is below rotation threshold.
// - Rotation threshold in rpm, reset 20, range 0 to 1000, immediate.
// - Rotation flag reaches a terminal only when its function code is 132.
// - Zero-speed flag set while absolute speed is below zero-speed threshold.
// - Zero-speed flag reaches a terminal only when its function code is 133.
// - Match flag set while speed minus command magnitude is within threshold.
// - Match threshold in rpm, reset 10, range 0 to 100, immediate.
// - Match flag reaches a terminal only when its function code is 136.
// - Near flag set while absolute filtered speed exceeds approach threshold.
// - Approach threshold in rpm, reset 100, range 10 to 6000, immediate.
// - Near flag reaches a terminal only when its function code is 137.
`define SPD_W 16
`define THR_W 13
`define FUNC_W 8
`define DO_NUM 4
`define ROT_THR_RST 13'h0014
`define ROT_THR_MIN 13'h0000
`define ROT_THR_MAX 13'h03E8
`define ZERO_THR_RST 13'h000A
`define ZERO_THR_MIN 13'h0000
`define ZERO_THR_MAX 13'h1770
`define MATCH_THR_RST 13'h000A
`define MATCH_THR_MIN 13'h0000
`define MATCH_THR_MAX 13'h0064
`define APPR_THR_RST 13'h0064
`define APPR_THR_MIN 13'h000A
`define APPR_THR_MAX 13'h1770
`define FUNC_ROTATION 8'h84
`define FUNC_ZERO_SPEED 8'h85
`define FUNC_SPEED_MATCH 8'h88
`define FUNC_SPEED_NEAR 8'h89
`endif

//--- verilog/speed_status_pkg.sv
// Types shared by the speed status comparator block.
`default_nettype none
`include "speed_status_cfg.svh"
package speed_status_pkg;
  typedef struct packed {
    logic [`THR_W-1:0] rotation;
    logic [`THR_W-1:0] zero;
    logic [`THR_W-1:0] match;
    logic [`THR_W-1:0] approach;
  } thresholds_t;
  typedef struct packed {
    logic rotation;
    logic zero;
    logic match;
    logic near;
  } speed_flags_t;
endpackage
`default_nettype wire

//--- verilog/threshold_clamp.sv
// Clamps a requested threshold setting into its accepted range.
`include "speed_status_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module threshold_clamp #(
  parameter logic [`THR_W-1:0] MIN_VAL = 13'h0000,
  parameter logic [`THR_W-1:0] MAX_VAL = 13'h1FFF
) (
  // Requested setting.
  input wire logic [`THR_W-1:0] req,
  // Setting within range.
  output logic [`THR_W-1:0] value
);
  always_comb begin
    if (req < MIN_VAL) begin
      value = MIN_VAL;
    end else if (req > MAX_VAL) begin
      value = MAX_VAL;
    end else begin
      value = req;
    end
  end
endmodule
`default_nettype wire

//--- bench/host_reader.sv
// Host controller model that latches the drive's output terminals.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  // Clock.
  input wire logic clk_sys,
  // Terminal levels.
  input wire logic [3:0] do_in,
  output logic [3:0] seen_r
);
  // The host polls once per clock, so it sees terminals a cycle late.
  always_ff @(posedge clk_sys) begin
    seen_r <= do_in;
  end
endmodule
`default_nettype wire

//--- bench/test_speed_status_outputs.sv
// Self-checking bench for the speed status comparator block.
`include "speed_status_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_speed_status_outputs;
  import speed_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sample_update = 1'b0;
  logic thr_write = 1'b0;
  logic signed [15:0] motor_speed = 16'sh0000;
  logic signed [15:0] speed_command = 16'sh0000;
  thresholds_t thr_req = '0;
  logic [31:0] do_function = 32'h89888584;
  speed_flags_t flags;
  logic [3:0] do_out;
  logic [3:0] host_seen;
  thresholds_t thr_now;
  thresholds_t thr_exp;
  int n_fail = 0;
  int n_tests = 0;
  always #20 clk_sys = ~clk_sys;
  speed_status_outputs i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .sample_update(sample_update), .motor_speed(motor_speed),
    .speed_command(speed_command), .thr_write(thr_write),
    .thr_req(thr_req), .do_function(do_function), .flags(flags),
    .do_out(do_out), .thr_now(thr_now));
  host_reader i_host (.clk_sys(clk_sys), .do_in(do_out),
    .seen_r(host_seen));
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic int lim(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  function automatic speed_flags_t exp_flags(int v, int c);
    int av = v < 0 ? -v : v;
    int d = v - c < 0 ? c - v : v - c;
    exp_flags.rotation = av >= thr_exp.rotation;
    exp_flags.zero = av < thr_exp.zero;
    exp_flags.match = d <= thr_exp.match;
    exp_flags.near = av > thr_exp.approach;
  endfunction
  function automatic logic [3:0] exp_do(speed_flags_t f);
    logic [7:0] k;
    for (int i = 0; i < 4; i++) begin
      k = do_function[8*i +: 8];
      exp_do[i] = (k == `FUNC_ROTATION && f.rotation)
        || (k == `FUNC_ZERO_SPEED && f.zero)
        || (k == `FUNC_SPEED_MATCH && f.match)
        || (k == `FUNC_SPEED_NEAR && f.near);
    end
  endfunction
  task automatic wr(int r, int z, int m, int a);
    @(posedge clk_sys);
    thr_write <= 1'b1;
    thr_req <= {13'(r), 13'(z), 13'(m), 13'(a)};
    thr_exp = {13'(lim(r, 0, 1000)), 13'(lim(z, 0, 6000)),
      13'(lim(m, 0, 100)), 13'(lim(a, 10, 6000))};
    @(posedge clk_sys);
    thr_write <= 1'b0;
    @(negedge clk_sys);
    check("thr_now", thr_now, thr_exp);
  endtask
  task automatic smp(int v, int c);
    speed_flags_t f;
    f = exp_flags(v, c);
    @(posedge clk_sys);
    sample_update <= 1'b1;
    motor_speed <= 16'(v);
    speed_command <= 16'(c);
    @(posedge clk_sys);
    sample_update <= 1'b0;
    @(negedge clk_sys);
    check("flags", flags, f);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("terminals", host_seen, exp_do(f));
  endtask
  // A stuck run is cut short and reported as a failure.
  initial begin
    #1000000;
    n_fail++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hd629f88d));
    thr_exp = {`ROT_THR_RST, `ZERO_THR_RST, `MATCH_THR_RST, `APPR_THR_RST};
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    check("reset thr", thr_now, thr_exp);
    check("reset do", do_out, 4'h0);
    check("reset flags", flags, 4'h0);
    smp(20, 0);
    smp(-19, 10);
    smp(-10, 0);
    smp(9, 19);
    smp(100, 90);
    smp(101, 112);
    wr(8191, 8191, 8191, 0);
    smp(1000, -100);
    for (int i = 0; i < 200; i++) begin
      if (i % 8 == 0) begin
        wr($urandom_range(0, 300), $urandom_range(0, 300),
          $urandom_range(0, 120), $urandom_range(0, 300));
      end
      if (i == 100) begin
        @(posedge clk_sys);
        do_function <= 32'h86898884;
      end
      smp(int'($urandom_range(0, 600)) - 300,
        int'($urandom_range(0, 600)) - 300);
    end
    // A second reset in mid-run must restore the defaults and clear flags.
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    thr_exp = {`ROT_THR_RST, `ZERO_THR_RST, `MATCH_THR_RST, `APPR_THR_RST};
    @(negedge clk_sys);
    check("rerun thr", thr_now, thr_exp);
    check("rerun flags", flags, 4'h0);
    check("rerun do", do_out, 4'h0);
    smp(20, 0);
    smp(-19, 10);
    end_sim;
  end
endmodule
`default_nettype wire
